// ===== rtl/chan_regs.sv
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/100ps
module chan_regs
   import chan_regs_pkg::*;
#(
   parameter bit FOUR_CHANNEL = 1'b1
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // avalon-mm slave
   input  wire logic [5:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   // conversion results from the converter core
   input  wire logic [11:0] chan2_result,
   input  wire logic [11:0] chan3_result,
   input  wire logic        result_valid,
   // control to the converter core
   output logic             convert_enable,
   output logic             chip_ready
);

   // state
   conv_state_t state_r, state_nxt;
   logic [7:0]  ctrl_r, ctrl_nxt;
   logic [11:0] c2_r, c2_nxt;
   logic [11:0] c3_r, c3_nxt;
   logic [4:0]  wait_r, wait_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic        ack_r, ack_nxt;
   logic        wreq_r, wreq_nxt;
   logic        conv_r, conv_nxt;
   logic        ready_r, ready_nxt;
   logic        wr_ctrl;
   logic        do_full_reset;

   // word index decode, low two address bits ignored so unaligned addresses map too
   function automatic logic [3:0] reg_index(input logic [5:0] a);
      reg_index = a[5:2];
   endfunction : reg_index

   // control write with low byte lane enabled
   always_comb begin
      wr_ctrl = write && !ack_r && byteenable[0]
                && reg_index(address) == IDX_RESET_AND_CONFIG;
      do_full_reset = wr_ctrl && writedata[BIT_FULL_RESET];
   end

   // next-state logic
   always_comb begin
      state_nxt = state_r;
      ctrl_nxt  = ctrl_r;
      c2_nxt    = c2_r;
      c3_nxt    = c3_r;
      wait_nxt  = wait_r;
      ack_nxt   = (read || write) && !ack_r;
      wreq_nxt  = !ack_nxt; // registered so the pin comes from a flop
      rdata_nxt = rdata_r;
      conv_nxt  = 1'b0;
      ready_nxt = ready_r;
      // register write; reserved bits stored as written
      if (wr_ctrl) begin
         ctrl_nxt = writedata[7:0];
      end
      // readback, one wait cycle per access
      if (read && !ack_r) begin
         if (reg_index(address) == IDX_CHAN2_RESULT_LOW) begin
            rdata_nxt = {24'h000000, c2_r[7:0]};
         end else if (reg_index(address) == IDX_CHAN2_RESULT_HIGH) begin
            rdata_nxt = {28'h0000000, c2_r[11:8]};
         end else if (reg_index(address) == IDX_CHAN3_RESULT_LOW) begin
            rdata_nxt = {24'h000000, c3_r[7:0]};
         end else if (reg_index(address) == IDX_CHAN3_RESULT_HIGH) begin
            rdata_nxt = {28'h0000000, c3_r[11:8]};
         end else if (reg_index(address) == IDX_RESET_AND_CONFIG) begin
            rdata_nxt = {24'h000000, ctrl_r};
         end else if (reg_index(address) == IDX_READY_STATUS) begin
            rdata_nxt = {31'h00000000, ready_r};
         end else begin
            rdata_nxt = UNMAPPED_READ;
         end
      end
      case (state_r)
         // not ready: counting down after a reset
         ST_SETUP: begin
            ready_nxt = 1'b0;
            if (wait_r == 5'h00) begin
               ready_nxt = 1'b1;
               state_nxt = ST_RUN;
            end else begin
               wait_nxt = wait_r - 5'h01;
            end
         end
         // converting: capture fresh results only here
         ST_RUN: begin
            conv_nxt = 1'b1;
            if (result_valid && FOUR_CHANNEL) begin
               c2_nxt = chan2_result;
               c3_nxt = chan3_result;
            end
            if (ctrl_nxt[BIT_CONFIG_HOLD]) begin
               state_nxt = ST_HOLD;
               conv_nxt  = 1'b0;
            end
         end
         // configuration hold: results frozen, control register still writable
         ST_HOLD: begin
            if (!ctrl_nxt[BIT_CONFIG_HOLD]) begin
               state_nxt = ST_RUN;
               conv_nxt  = 1'b1;
            end
         end
         default: begin
            state_nxt = ST_SETUP;
         end
      endcase
      // full reset restores every register except read data and handshake flops to default
      if (do_full_reset) begin
         ctrl_nxt  = CTRL_RESET_VALUE;
         c2_nxt    = RESULT_RESET_VALUE;
         c3_nxt    = RESULT_RESET_VALUE;
         wait_nxt  = READY_DELAY;
         state_nxt = ST_SETUP;
         conv_nxt  = 1'b0;
         ready_nxt = 1'b0;
      end
   end

   // registers
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_r <= ST_SETUP;
         ctrl_r  <= CTRL_RESET_VALUE;
         c2_r    <= RESULT_RESET_VALUE;
         c3_r    <= RESULT_RESET_VALUE;
         wait_r  <= READY_DELAY;
         rdata_r <= 32'h0000_0000;
         ack_r   <= 1'b0;
         wreq_r  <= 1'b1;
         conv_r  <= 1'b0;
         ready_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         ctrl_r  <= ctrl_nxt;
         c2_r    <= c2_nxt;
         c3_r    <= c3_nxt;
         wait_r  <= wait_nxt;
         rdata_r <= rdata_nxt;
         ack_r   <= ack_nxt;
         wreq_r  <= wreq_nxt;
         conv_r  <= conv_nxt;
         ready_r <= ready_nxt;
      end
   end

   // outputs straight from flops
   always_comb begin
      readdata       = rdata_r;
      waitrequest    = wreq_r;
      convert_enable = conv_r;
      chip_ready     = ready_r;
   end

endmodule : chan_regs

// ===== rtl/chan_regs_pkg.sv
// Behaviour
// - channel 2 low register shows result bits 7:0; four-channel variant only.
// - channel 2 high register bits 3:0 show result 11:8; bits 7:4 read zero.
// - channel 3 low register shows result bits 7:0; four-channel variant only.
// - channel 3 high register bits 3:0 show result 11:8; upper bits zero.
// - writing one to control bit 4 resets the device and all registers; the read data and handshake flops keep their values.
// - after full reset, normal operation waits until chip ready reads one.
// - control bit 0 high holds configuration mode, no conversion, settings kept.
// - clearing the hold bit returns the device to normal conversion.
package chan_regs_pkg;
   // register indices, byte address is four times the index
   localparam logic [3:0] IDX_CHAN2_RESULT_LOW  = 4'h6;
   localparam logic [3:0] IDX_CHAN2_RESULT_HIGH = 4'h7;
   localparam logic [3:0] IDX_CHAN3_RESULT_LOW  = 4'h8;
   localparam logic [3:0] IDX_CHAN3_RESULT_HIGH = 4'h9;
   localparam logic [3:0] IDX_RESET_AND_CONFIG  = 4'ha;
   localparam logic [3:0] IDX_READY_STATUS      = 4'hb;
   // field positions of the control and ready status registers
   localparam int         BIT_FULL_RESET        = 4;
   localparam int         BIT_CONFIG_HOLD       = 0;
   localparam int         BIT_CHIP_READY        = 0;
   // reset values
   localparam logic [7:0] CTRL_RESET_VALUE      = 8'h00;
   localparam logic [11:0] RESULT_RESET_VALUE   = 12'h000;
   // countdown start; the chip stays not ready one cycle longer than this count, after reset and after a full reset request
   localparam int         READY_DELAY_CYCLES    = 16;
   localparam logic [4:0] READY_DELAY           = 5'(READY_DELAY_CYCLES);
   // read data for unmapped addresses
   localparam logic [31:0] UNMAPPED_READ        = 32'h0000_0000;

   typedef enum logic [1:0] {
      ST_SETUP   = 2'b00,
      ST_RUN     = 2'b01,
      ST_HOLD    = 2'b11
   } conv_state_t;
endpackage : chan_regs_pkg

// ===== sim/avmm_host.sv
`timescale 1ns/100ps
module avmm_host (
   // clock and answer
   input  wire logic        clock,
   input  wire logic        waitrequest,
   input  wire logic [31:0] readdata,
   // request
   output logic      [5:0]  address = 6'h00,
   output logic             read = 1'b0,
   output logic             write = 1'b0,
   output logic      [31:0] writedata = 32'h0,
   output logic      [3:0]  byteenable = 4'hf,
   output logic             hung = 1'b0
);
   // one access, held until waitrequest low
   task acc(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
      int n;
      @(posedge clock);
      address <= a;
      read <= !w;
      write <= w;
      writedata <= {24'h0, d & 8'h11};
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (waitrequest !== 1'b0 && n < 64);
      q = readdata[7:0];
      hung <= n >= 64;
      read <= 1'b0;
      write <= 1'b0;
      address <= ~a; // released lines scrambled
      writedata <= ~writedata;
   endtask : acc
endmodule : avmm_host

// ===== sim/chan_regs_asserts.sv
`timescale 1ns/100ps
module chan_regs_asserts (
   // watched ports
   input wire logic        clock,
   input wire logic        reset,
   input wire logic [5:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [3:0]  byteenable,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic        convert_enable,
   input wire logic        chip_ready
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // control write being taken
   logic ctl_w;
   assign ctl_w = write && waitrequest && byteenable[0] && address[5:2] == 4'ha;
   a_ack_next: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("no answer one cycle after request");
   a_ack_single: assert property (!waitrequest |=> waitrequest)
      else $error("answer longer than one cycle");
   a_c2_upper: assert property (read && !waitrequest && address[5:2] == 4'h7 |-> readdata[31:4] == 0)
      else $error("chan2 high reserved bits set");
   a_c3_upper: assert property (read && !waitrequest && address[5:2] == 4'h9 |-> readdata[31:4] == 0)
      else $error("chan3 high reserved bits set");
   a_hold_stop: assert property (ctl_w && writedata[0] && !writedata[4] |-> ##[1:3] !convert_enable)
      else $error("conversion not stopped by hold");
   a_run_again: assert property (ctl_w && writedata[4:0] == 0 && chip_ready |-> ##[1:3] convert_enable)
      else $error("conversion not resumed");
   a_reset_drop: assert property (ctl_w && writedata[4] |-> ##[1:2] !chip_ready)
      else $error("full reset not taken");
   a_ready_first: assert property ($rose(convert_enable) |-> chip_ready)
      else $error("conversion before ready");
   a_ready_wait: assert property ($rose(chip_ready) |-> !$past(chip_ready, 12))
      else $error("ready came too soon");
endmodule : chan_regs_asserts
bind chan_regs chan_regs_asserts i_chan_regs_asserts (.clock, .reset, .address, .read, .write,
   .writedata, .byteenable, .readdata, .waitrequest, .convert_enable, .chip_ready);

// ===== sim/tb.sv
`timescale 1ns/100ps
module tb;
   logic clock = 0, reset = 1, result_valid = 0, hold = 0;
   logic [11:0] chan2_result = 0, chan3_result = 0, m2 = 0, m3 = 0;
   logic [5:0] address;
   logic [31:0] writedata, readdata;
   logic [3:0] byteenable;
   logic [7:0] q;
   logic read, write, waitrequest, convert_enable, chip_ready, hung;
   int error_cnt = 0, tests_run = 0;
   always #4 clock = ~clock;
   chan_regs i_chan_regs (.clock, .reset, .address, .read, .write, .writedata, .byteenable,
      .readdata, .waitrequest, .chan2_result, .chan3_result, .result_valid, .convert_enable,
      .chip_ready);
   avmm_host i_avmm_host (.clock, .waitrequest, .readdata, .address, .read, .write,
      .writedata, .byteenable, .hung);
   task wrap_up();
      $display("counts: %0d run, %0d errors", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up
   task chk(input logic [7:0] s, input logic [7:0] e);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("unexpected at %0t: %h vs %h", $time, s, e);
      end
   endtask : chk
   // host hang ends the run
   always @(posedge clock) if (hung) begin
      error_cnt++;
      wrap_up();
   end
   // bounded wait on conversion state
   task wce(input logic v);
      int n;
      n = 0;
      while (convert_enable !== v && n < 100) begin
         @(posedge clock);
         n++;
      end
      if (n >= 100) begin
         error_cnt++;
         wrap_up();
      end
   endtask : wce
   // new results; model keeps them unless held
   task push();
      logic [11:0] a, b;
      a = 12'($urandom);
      b = 12'($urandom);
      @(posedge clock);
      chan2_result <= a;
      chan3_result <= b;
      result_valid <= 1'b1;
      if (!hold) {m2, m3} = {a, b};
      @(posedge clock);
      result_valid <= 1'b0;
   endtask : push
   task rdall();
      logic [7:0] e [4];
      e = '{m2[7:0], 8'(m2[11:8]), m3[7:0], 8'(m3[11:8])};
      for (int i = 0; i < 4; i++) begin
         i_avmm_host.acc(0, 6'h18 + 6'(4 * i), 8'h00, q);
         chk(q, e[i]);
      end
   endtask : rdall
   initial begin
      void'($urandom(32'h60dc));
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      wce(1);
      rdall();
      i_avmm_host.acc(0, 6'h28, 8'h00, q);
      chk(q, 8'h00);
      i_avmm_host.acc(0, 6'h3c, 8'h00, q);
      chk(q, 8'h00);
      $display("test reset done");
      repeat (4) begin
         push();
         i_avmm_host.acc(1, 6'h18, 8'hff, q);
         rdall();
      end
      $display("test results done");
      i_avmm_host.acc(1, 6'h28, 8'h01, q);
      hold = 1;
      wce(0);
      push();
      rdall();
      i_avmm_host.acc(0, 6'h28, 8'h00, q);
      chk(q, 8'h01);
      i_avmm_host.acc(1, 6'h28, 8'h00, q);
      hold = 0;
      wce(1);
      push();
      rdall();
      $display("test hold done");
      i_avmm_host.acc(1, 6'h28, 8'h10, q);
      {m2, m3} = 24'h0;
      i_avmm_host.acc(0, 6'h2c, 8'h00, q);
      chk(q, 8'h00);
      wce(1);
      i_avmm_host.acc(0, 6'h2c, 8'h00, q);
      chk(q, 8'h01);
      rdall();
      $display("test full reset done");
      wrap_up();
   end
endmodule : tb
